// *** serial_link_pkg.sv ***
// serial_link_pkg: constants, field layouts and state types shared by
// the serial link slave controller.
// assumes a single 40 MHz clock; link and host pins are synchronous to it.
package serial_link_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;     // 40 MHz
  localparam int BIT_TIME_NS    = 10000;  // one link bit
  localparam int BIT_CYCLES     = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int CS_HOLDOFF_NS  = 32000;  // chip select lockout
  localparam int HOLDOFF_CYCLES = (CS_HOLDOFF_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int TIMER_W        = 16;

  // ----------------------------------------------------------------
  // frame layout on the link: start, cmd, addr, data, parity, stop
  // ----------------------------------------------------------------
  localparam logic [3:0] RX_LAST_IDX  = 4'hd;  // 14 samples after start
  localparam logic [3:0] TX_LAST_IDX  = 4'he;  // 15 bits per frame
  localparam logic [2:0] UNIVERSAL_ADDR = 3'h0;

  // ----------------------------------------------------------------
  // host serial access
  // ----------------------------------------------------------------
  localparam logic       HDR_READ    = 1'b1;   // direction header
  localparam logic       SEL_REG_ONE = 1'b1;   // status / link control
  localparam logic [4:0] RX_REG_LEN  = 5'h0e;  // received_frame bits
  localparam logic [4:0] ST_REG_LEN  = 5'h01;  // output_status bits
  localparam logic [4:0] TX_REG_LEN  = 5'h0c;  // transmit_frame bits
  localparam logic [4:0] LC_REG_LEN  = 5'h07;  // link_control bits
  localparam logic [4:0] FIRST_DATA  = 5'h02;  // rises before data

  // ----------------------------------------------------------------
  // register layouts, first shifted bit at the msb
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cmd;
    logic [2:0] addr;
    logic [7:0] data;
  } frame_t;

  typedef struct packed {
    logic   framing_error_flag;
    logic   parity_error_flag;
    frame_t frame;
  } received_frame_t;

  typedef struct packed {
    logic       transmit_disable;
    logic       test;
    logic       trap_all_enable;
    logic       pass_through_enable;
    logic [2:0] match_address;
  } link_control_t;

  localparam received_frame_t RX_REG_RESET = 14'h0000;
  localparam link_control_t   LC_REG_RESET = 7'h00;
  localparam frame_t          FRAME_RESET  = 12'h000;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_ACTIVE = 2'b01,
    H_DONE   = 2'b11
  } host_state_t;

  typedef enum logic [1:0] {
    R_IDLE  = 2'b00,
    R_START = 2'b01,
    R_DATA  = 2'b11
  } rx_state_t;

  typedef enum logic {
    T_IDLE = 1'b0,
    T_SEND = 1'b1
  } tx_state_t;

endpackage : serial_link_pkg

// *** serial_link_slave_controller.sv ***
// serial_link_slave_controller: link receiver, retransmitter and
// four serial shift registers reached over chip select / serial clock.
// assumes all inputs synchronous to clk_in; srst_in is power-on reset.
//
// Summary of operation
// - auxiliary clock toggles at half input rate
// - chip select ignored for holdoff after reset
// - every link bit lasts one bit time
// - two read and two write serial registers
// - fixed shift order, error flag first out
// - received frame read releases interrupt
// - framing flag sticky until received frame read
// - parity flag reflects most recent trapped frame
// - received register holds command, address, data
// - busy while written frame awaits sending
// - completed transmit write starts a frame
// - transmit disable blocks retransmitting unmatched frames
// - test mode loops output into input
// - trap-all mode traps every frame
// - pass-through picks send or return output
// - address match traps frame
// - all register bits reset to zero
// - access is header, select, data clocks
// - header one reads, select one register one
// - universal, matched or bad frames get trapped
// - trapped frame pulls interrupt low
`timescale 1ns/1ps
module serial_link_slave_controller #(
  parameter int BIT_CYCLES     = serial_link_pkg::BIT_CYCLES,
  parameter int HOLDOFF_CYCLES = serial_link_pkg::HOLDOFF_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic cs_in,
  input  wire logic host_serial_clock_in,
  input  wire logic host_serial_in_in,
  output logic      host_serial_out_out,
  input  wire logic send_in,
  input  wire logic return_in,
  output logic      send_out,
  output logic      return_out,
  output logic      half_rate_clock_out,
  output logic      int_n_out,
  output logic      nmi_n_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

  serial_link_pkg::received_frame_t received_frame;
  serial_link_pkg::link_control_t   link_control;
  serial_link_pkg::frame_t          transmit_frame;
  serial_link_pkg::frame_t          fwd_frame;
  serial_link_pkg::host_state_t     host_state;
  serial_link_pkg::rx_state_t       rx_state;
  serial_link_pkg::tx_state_t       tx_state;

  logic        output_busy;
  logic [15:0] holdoff;
  logic        sclk_prev;
  logic [4:0]  rise_cnt;
  logic [4:0]  acc_len;
  logic        acc_read;
  logic        acc_sel;
  logic [13:0] rd_shift;
  logic [11:0] wr_shift;
  logic        sclk_rise;
  logic        data_rise;
  logic        access_done;
  logic        rx_reg_read;
  logic [15:0] rx_timer;
  logic [3:0]  rx_idx;
  logic [12:0] rx_shift;
  logic [13:0] rx_bits;
  logic        rx_line;
  logic        rx_end;
  logic        rx_framing_error_flag;
  logic        rx_parity_error_flag;
  logic        rx_trap;
  logic        fwd_pend;
  logic [15:0] tx_timer;
  logic [3:0]  tx_idx;
  logic [14:0] tx_shift;
  logic        tx_line;
  logic        tx_tick;
  logic        tx_load;

  // ----------------------------------------------------------------
  // clock out and reset-related outputs
  // ----------------------------------------------------------------
  // half rate square wave, held low in reset
  always_ff @(posedge clk_in) begin
    if (srst_in) half_rate_clock_out <= 1'b0;
    else         half_rate_clock_out <= ~half_rate_clock_out;
  end

  // nmi low while reset held; lockout counts from its release
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      nmi_n_out <= 1'b0;
      holdoff   <= 16'(HOLDOFF_CYCLES);
    end else begin
      nmi_n_out <= 1'b1;
      if (holdoff != 16'h0000) holdoff <= holdoff - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // host serial access
  // ----------------------------------------------------------------
  assign sclk_rise   = host_serial_clock_in & ~sclk_prev;
  assign data_rise   = sclk_rise && host_state == serial_link_pkg::H_ACTIVE
                       && rise_cnt >= serial_link_pkg::FIRST_DATA;
  assign access_done = data_rise && rise_cnt == acc_len + 5'h01;
  assign rx_reg_read = access_done && acc_read
                       && acc_sel != serial_link_pkg::SEL_REG_ONE;

  // header, select, data clocks; deselect aborts at once
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sclk_prev  <= 1'b0;
      host_state <= serial_link_pkg::H_IDLE;
      rise_cnt   <= 5'h00;
      acc_len    <= 5'h00;
      acc_read   <= 1'b0;
      acc_sel    <= 1'b0;
    end else begin
      sclk_prev <= host_serial_clock_in;
      if (!cs_in) begin
        host_state <= serial_link_pkg::H_IDLE;
      end else begin
        case (host_state)
          serial_link_pkg::H_IDLE: begin
            rise_cnt <= 5'h00;
            if (holdoff == 16'h0000)
              host_state <= serial_link_pkg::H_ACTIVE;
          end
          serial_link_pkg::H_ACTIVE: begin
            if (sclk_rise) begin
              rise_cnt <= rise_cnt + 5'h01;
              if (rise_cnt == 5'h00) acc_read <= host_serial_in_in;
              if (rise_cnt == 5'h01) begin
                acc_sel <= host_serial_in_in;
                if (host_serial_in_in == serial_link_pkg::SEL_REG_ONE)
                  acc_len <= acc_read ? serial_link_pkg::ST_REG_LEN
                                      : serial_link_pkg::LC_REG_LEN;
                else
                  acc_len <= acc_read ? serial_link_pkg::RX_REG_LEN
                                      : serial_link_pkg::TX_REG_LEN;
              end
              if (access_done) host_state <= serial_link_pkg::H_DONE;
            end
          end
          serial_link_pkg::H_DONE: host_state <= serial_link_pkg::H_DONE;
          default: host_state <= serial_link_pkg::H_IDLE;
        endcase
      end
    end
  end

  // read shifter: snapshot after select, msb first out
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rd_shift            <= 14'h0000;
      host_serial_out_out <= 1'b0;
    end else begin
      if (sclk_rise && host_state == serial_link_pkg::H_ACTIVE
          && rise_cnt == 5'h01) begin
        if (host_serial_in_in == serial_link_pkg::SEL_REG_ONE)
          rd_shift <= {output_busy, 13'h0000};
        else
          rd_shift <= received_frame;
      end else if (data_rise) begin
        rd_shift <= {rd_shift[12:0], 1'b0};
      end
      host_serial_out_out <= rd_shift[13];
    end
  end

  // write shifter and write-only registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_shift       <= 12'h000;
      transmit_frame <= serial_link_pkg::FRAME_RESET;
      link_control   <= serial_link_pkg::LC_REG_RESET;
    end else begin
      if (data_rise) wr_shift <= {wr_shift[10:0], host_serial_in_in};
      if (access_done && !acc_read) begin
        if (acc_sel == serial_link_pkg::SEL_REG_ONE)
          link_control <= {wr_shift[5:0], host_serial_in_in};
        else
          transmit_frame <= {wr_shift[10:0], host_serial_in_in};
      end
    end
  end

  // ----------------------------------------------------------------
  // link receiver
  // ----------------------------------------------------------------
  assign rx_line = link_control.test ? tx_line : send_in;
  assign rx_end  = rx_state == serial_link_pkg::R_DATA
                   && rx_timer == 16'h0000
                   && rx_idx == serial_link_pkg::RX_LAST_IDX;
  assign rx_bits = {rx_shift, rx_line};
  assign rx_framing_error_flag = ~rx_bits[0];
  assign rx_parity_error_flag = ^rx_bits[13:1];
  assign rx_trap = link_control.trap_all_enable
                 || rx_bits[12:10] == serial_link_pkg::UNIVERSAL_ADDR
                 || rx_bits[12:10] == link_control.match_address
                 || rx_framing_error_flag || rx_parity_error_flag
                 || link_control.transmit_disable;

  // start found at mid bit, then one sample per bit time
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_state <= serial_link_pkg::R_IDLE;
      rx_timer <= 16'h0000;
      rx_idx   <= 4'h0;
      rx_shift <= 13'h0000;
    end else begin
      case (rx_state)
        serial_link_pkg::R_IDLE: begin
          rx_timer <= HALF_LAST;
          if (!rx_line) rx_state <= serial_link_pkg::R_START;
        end
        serial_link_pkg::R_START: begin
          if (rx_timer != 16'h0000) begin
            rx_timer <= rx_timer - 16'h0001;
          end else begin
            rx_timer <= BIT_LAST;
            rx_idx   <= 4'h0;
            rx_state <= rx_line ? serial_link_pkg::R_IDLE
                                : serial_link_pkg::R_DATA;
          end
        end
        serial_link_pkg::R_DATA: begin
          if (rx_timer != 16'h0000) begin
            rx_timer <= rx_timer - 16'h0001;
          end else begin
            rx_timer <= BIT_LAST;
            rx_idx   <= rx_idx + 4'h1;
            rx_shift <= {rx_shift[11:0], rx_line};
            if (rx_end) rx_state <= serial_link_pkg::R_IDLE;
          end
        end
        default: rx_state <= serial_link_pkg::R_IDLE;
      endcase
    end
  end

  // trapped frames load received register; a new trap beats a read
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      received_frame <= serial_link_pkg::RX_REG_RESET;
      int_n_out      <= 1'b1;
    end else if (rx_end && rx_trap) begin
      received_frame.framing_error_flag <=
        rx_framing_error_flag | (received_frame.framing_error_flag & ~rx_reg_read);
      received_frame.parity_error_flag  <= rx_parity_error_flag;
      received_frame.frame <= rx_bits[13:2];
      int_n_out <= 1'b0;
    end else if (rx_reg_read) begin
      received_frame.framing_error_flag <= 1'b0;
      int_n_out <= 1'b1;
    end
  end

  // unmatched good frames wait one deep for the output shifter
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fwd_pend  <= 1'b0;
      fwd_frame <= serial_link_pkg::FRAME_RESET;
    end else if (rx_end && !rx_trap) begin
      fwd_pend  <= 1'b1;
      fwd_frame <= rx_bits[13:2];
    end else if (tx_load && fwd_pend) begin
      fwd_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link transmitter
  // ----------------------------------------------------------------
  assign tx_line = tx_shift[14];
  assign tx_tick = tx_state == serial_link_pkg::T_SEND
                   && tx_timer == 16'h0000;
  assign tx_load = tx_state == serial_link_pkg::T_IDLE
                   && (fwd_pend || output_busy);

  // retransmit first, then the host frame; bits msb first
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_state <= serial_link_pkg::T_IDLE;
      tx_shift <= 15'h7fff;
      tx_timer <= 16'h0000;
      tx_idx   <= 4'h0;
    end else if (tx_load) begin
      tx_state <= serial_link_pkg::T_SEND;
      tx_timer <= BIT_LAST;
      tx_idx   <= 4'h0;
      if (fwd_pend)
        tx_shift <= {1'b0, fwd_frame, ^fwd_frame, 1'b1};
      else
        tx_shift <= {1'b0, transmit_frame, ^transmit_frame, 1'b1};
    end else if (tx_state == serial_link_pkg::T_SEND) begin
      if (!tx_tick) begin
        tx_timer <= tx_timer - 16'h0001;
      end else begin
        tx_timer <= BIT_LAST;
        tx_shift <= {tx_shift[13:0], 1'b1};
        tx_idx   <= tx_idx + 4'h1;
        if (tx_idx == serial_link_pkg::TX_LAST_IDX)
          tx_state <= serial_link_pkg::T_IDLE;
      end
    end
  end

  // busy from completed transmit write until taken; set wins
  always_ff @(posedge clk_in) begin
    if (srst_in)
      output_busy <= 1'b0;
    else if (access_done && !acc_read
             && acc_sel != serial_link_pkg::SEL_REG_ONE)
      output_busy <= 1'b1;
    else if (tx_load && !fwd_pend)
      output_busy <= 1'b0;
  end

  // pin routing for pass-through, loop-back and test
  assign send_out   = link_control.pass_through_enable
                      && !link_control.test ? tx_line : 1'b1;
  assign return_out = link_control.pass_through_enable
                      || link_control.test ? return_in : tx_line;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // cycles the tx line has held its level, for the bit time check
  logic        line_prev;
  logic [15:0] line_age;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      line_prev <= 1'b1;
      line_age  <= 16'h0000;
    end else begin
      line_prev <= tx_line;
      if (tx_line != line_prev)      line_age <= 16'h0000;
      else if (line_age != 16'hffff) line_age <= line_age + 16'h0001;
    end
  end

  sequence rx_read_end_s;
    rx_reg_read && !(rx_end && rx_trap);
  endsequence

  half_clock_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !$past(srst_in) |-> half_rate_clock_out != $past(half_rate_clock_out))
    else $error("half rate clock stopped toggling");
  cs_lockout_a: assert property (@(posedge clk_in) disable iff (srst_in)
    holdoff != 16'h0000 |-> host_state == serial_link_pkg::H_IDLE)
    else $error("access began during chip select lockout");
  bit_width_a: assert property (@(posedge clk_in) disable iff (srst_in)
    tx_line != line_prev |-> line_age >= BIT_LAST)
    else $error("link bit shorter than bit time");
  read_release_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rx_read_end_s |=> int_n_out && !received_frame.framing_error_flag)
    else $error("received frame read did not release interrupt");
  trap_int_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rx_end && rx_trap |=> !int_n_out ##0
      received_frame.frame == $past(rx_bits[13:2]))
    else $error("trapped frame not stored or interrupt missing");
  busy_set_a: assert property (@(posedge clk_in) disable iff (srst_in)
    access_done && !acc_read && !acc_sel |=> output_busy)
    else $error("transmit write did not set busy");
  test_send_a: assert property (@(posedge clk_in) disable iff (srst_in)
    link_control.test |-> send_out && return_out == return_in)
    else $error("test mode routing wrong");
  abort_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !cs_in |=> host_state == serial_link_pkg::H_IDLE && !access_done)
    else $error("deselect did not abort access");
  forward_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rx_end && link_control.transmit_disable |=> $stable(fwd_frame))
    else $error("frame forwarded with transmit disabled");

endmodule : serial_link_slave_controller

// *** link_partner.sv ***
// link_partner: neighbour device on the ring link
// assumes the controller clock; an idle line sits at 1
`timescale 1ns/1ps
module link_partner #(
  parameter int BIT_CYCLES = 8
) (
  input  wire logic clk_in,
  input  wire logic send_line_in,
  input  wire logic ret_line_in,
  output logic      send_drv_out
);
  // ----------------------------------------------------------
  // frame sender and frame decoder
  // ----------------------------------------------------------
  initial send_drv_out = 1'b1;

  // selects which controller output is watched
  function automatic logic pick(input logic r);
    return r ? ret_line_in : send_line_in;
  endfunction : pick

  // msb first, one bit time per bit, then two idle bits
  task automatic send_frame(input logic [14:0] bits);
    for (int i = 14; i >= 0; i--) begin
      send_drv_out = bits[i];
      repeat (BIT_CYCLES) @(negedge clk_in);
    end
    send_drv_out = 1'b1;
    repeat (2 * BIT_CYCLES) @(negedge clk_in);
  endtask : send_frame

  // waits for a start bit, then samples every bit at mid bit
  task automatic get_frame(input logic from_ret, input int limit,
                           output logic [14:0] bits, output logic seen);
    int n;
    n = 0;
    bits = 15'h7fff;
    while (n < limit && pick(from_ret) !== 1'b0) begin
      @(negedge clk_in);
      n++;
    end
    seen = (n < limit);
    if (seen) begin
      repeat (BIT_CYCLES / 2) @(negedge clk_in);
      for (int i = 14; i >= 0; i--) begin
        bits[i] = pick(from_ret);
        if (i > 0) repeat (BIT_CYCLES) @(negedge clk_in);
      end
    end
  endtask : get_frame
endmodule : link_partner

// *** tb_top.sv ***
// tb_top: host-side bench for the serial link slave controller
// assumes link_partner on the send input; return input idles at 1
`timescale 1ns/1ps
module tb_top;
  localparam int BITC  = 200;
  localparam int HOLD  = 2000;
  localparam int HALF  = 2000 / serial_link_pkg::CLK_PERIOD_NS;
  localparam int LIMIT = 120000;
  logic        clk_in  = 1'b0;
  logic        srst_in = 1'b1;
  logic        cs_in   = 1'b0;
  logic        sck     = 1'b0;
  logic        sdi     = 1'b0;
  logic        ret_in  = 1'b1;
  logic        send_in;
  logic        sdo;
  logic        send_out;
  logic        return_out;
  logic        half_clk;
  logic        int_n;
  logic        nmi_n;
  logic        hc;
  logic        seen;
  logic [13:0] rd;
  logic [14:0] f1;
  logic [14:0] f2;
  int          err_total  = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  // ----------------------------------------------------------
  // clock, design and partner
  // ----------------------------------------------------------
  always #12.5 clk_in = ~clk_in;

  serial_link_slave_controller #(
    .BIT_CYCLES    (BITC),
    .HOLDOFF_CYCLES(HOLD)
  ) u_serial_link_slave_controller (
    .clk_in              (clk_in),
    .srst_in             (srst_in),
    .cs_in               (cs_in),
    .host_serial_clock_in(sck),
    .host_serial_in_in   (sdi),
    .host_serial_out_out (sdo),
    .send_in             (send_in),
    .return_in           (ret_in),
    .send_out            (send_out),
    .return_out          (return_out),
    .half_rate_clock_out (half_clk),
    .int_n_out           (int_n),
    .nmi_n_out           (nmi_n)
  );

  link_partner #(
    .BIT_CYCLES(BITC)
  ) u_link_partner (
    .clk_in      (clk_in),
    .send_line_in(send_out),
    .ret_line_in (return_out),
    .send_drv_out(send_in)
  );

  // ----------------------------------------------------------
  // compare, host access and link helpers
  // ----------------------------------------------------------
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_vec(input string nm, input logic [14:0] e,
                         input logic [14:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_vec

  // one serial clock, 2000 ns low then high, data set while low
  task automatic rise(input logic b);
    sdi = b;
    repeat (HALF) @(negedge clk_in);
    sck = 1'b1;
    repeat (HALF) @(negedge clk_in);
    sck = 1'b0;
  endtask : rise

  // header, select, data bits len-1 down to stop, deselect
  task automatic xfer(input logic rdn, input logic sel, input int len,
                      input int stop, input logic [13:0] w);
    rd = 14'h0000;
    cs_in = 1'b1;
    rise(rdn);
    rise(sel);
    for (int i = len - 1; i >= stop; i--) begin
      rd[i] = sdo;
      rise(w[i]);
    end
    repeat (HALF) @(negedge clk_in);
    cs_in = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : xfer

  task automatic rd_rx(input logic [13:0] e);
    xfer(1'b1, 1'b0, 14, 0, 14'h0000);
    chk_vec("received_frame", {1'b0, e}, {1'b0, rd});
  endtask : rd_rx

  task automatic rd_st(input logic e);
    xfer(1'b1, 1'b1, 1, 0, 14'h0000);
    chk_bit("output_status", e, rd[0]);
  endtask : rd_st

  function automatic logic [14:0] mk(input serial_link_pkg::frame_t fr,
                                     input logic bp, input logic bs);
    return {1'b0, fr, (^fr) ^ bp, ~bs};
  endfunction : mk

  // sends a frame on send_in and watches one output for its copy
  task automatic frame_case(input logic [14:0] f, input logic ret,
                            input logic e_seen, input logic e_int);
    fork
      u_link_partner.send_frame(f);
      u_link_partner.get_frame(ret, 20 * BITC, f1, seen);
    join
    if (e_seen !== 1'bx) chk_bit("forwarded", e_seen, seen);
    if (e_seen === 1'b1) chk_vec("forwarded frame", f, f1);
    chk_bit("int_n_out", e_int, int_n);
  endtask : frame_case

  // ----------------------------------------------------------
  // hang guard and main sequence
  // ----------------------------------------------------------
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      summarize();
    end
  end

  // reset, then one scenario after another
  initial begin
    repeat (5) @(negedge clk_in);
    chk_bit("nmi_n_out", 1'b0, nmi_n);
    chk_bit("half_rate_clock_out", 1'b0, half_clk);
    chk_bit("int_n_out", 1'b1, int_n);
    srst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk_bit("nmi_n_out", 1'b1, nmi_n);
    hc = half_clk;
    @(negedge clk_in);
    chk_bit("half_rate_clock_out", ~hc, half_clk);
    @(negedge clk_in);
    chk_bit("half_rate_clock_out", hc, half_clk);
    xfer(1'b0, 1'b1, 7, 0, 14'h0010);
    repeat (HOLD) @(negedge clk_in);
    rd_st(1'b0);
    rd_rx(14'h0000);
    frame_case(mk(12'h35a, 1'b0, 1'b0), 1'b1, 1'b1, 1'b1);
    xfer(1'b0, 1'b1, 7, 0, 14'h000d);
    ret_in = 1'b0;
    @(negedge clk_in);
    chk_bit("return_out", 1'b0, return_out);
    ret_in = 1'b1;
    frame_case(mk(12'h2a5, 1'b0, 1'b0), 1'b0, 1'b1, 1'b1);
    frame_case(mk(12'hdc3, 1'b0, 1'b0), 1'b0, 1'b0, 1'b0);
    xfer(1'b1, 1'b0, 14, 9, 14'h0000);
    chk_bit("int_n_out", 1'b0, int_n);
    rd_rx(14'h0dc3);
    chk_bit("int_n_out", 1'b1, int_n);
    frame_case(mk(12'h83c, 1'b0, 1'b0), 1'b0, 1'b0, 1'b0);
    rd_rx(14'h083c);
    frame_case(mk(12'h211, 1'b1, 1'b0), 1'b0, 1'b0, 1'b0);
    rd_rx(14'h1211);
    frame_case(mk(12'h222, 1'b0, 1'b1), 1'b0, 1'b0, 1'b0);
    xfer(1'b1, 1'b0, 14, 0, 14'h0000);
    chk_bit("framing_error_flag", 1'b1, rd[13]);
    frame_case(mk(12'h577, 1'b0, 1'b0), 1'b0, 1'b0, 1'b0);
    rd_rx(14'h0577);
    xfer(1'b0, 1'b1, 7, 0, 14'h004d);
    frame_case(mk(12'h2a5, 1'b0, 1'b0), 1'b0, 1'b0, 1'b0);
    xfer(1'b0, 1'b1, 7, 0, 14'h001d);
    frame_case(mk(12'h2a5, 1'b0, 1'b0), 1'b0, 1'bx, 1'b0);
    rd_rx(14'h02a5);
    xfer(1'b0, 1'b1, 7, 0, 14'h002d);
    xfer(1'b0, 1'b0, 12, 0, 14'h0d5a);
    u_link_partner.get_frame(1'b0, 20 * BITC, f1, seen);
    chk_bit("send_out frame", 1'b0, seen);
    chk_bit("int_n_out", 1'b0, int_n);
    ret_in = 1'b0;
    @(negedge clk_in);
    chk_bit("return_out test", 1'b0, return_out);
    ret_in = 1'b1;
    rd_rx(14'h0d5a);
    xfer(1'b0, 1'b1, 7, 0, 14'h000d);
    fork
      begin
        u_link_partner.get_frame(1'b0, 40 * BITC, f1, seen);
        u_link_partner.get_frame(1'b0, 40 * BITC, f2, seen);
      end
      begin
        xfer(1'b0, 1'b0, 12, 0, 14'h01e1);
        xfer(1'b0, 1'b0, 12, 0, 14'h03f0);
        rd_st(1'b1);
      end
    join
    chk_vec("first sent frame", mk(12'h1e1, 1'b0, 1'b0), f1);
    chk_vec("second sent frame", mk(12'h3f0, 1'b0, 1'b0), f2);
    rd_st(1'b0);
    summarize();
  end
endmodule : tb_top
